// *** csh_hub.sv ***
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "csh_map.svh"
module csh_hub
    import csh_pkg::*;
#(
    parameter int NCORE = 4,
    parameter int SETS = 64,
    parameter int L2_KB = 0
) (
    input wire logic pclk,
    input wire logic presetn,
    csh_if.hub lnk,
    input wire logic core_req_valid,
    output logic core_req_ready,
    input wire logic [1:0] core_req_id,
    input wire csh_op_t core_req_op,
    input wire csh_shr_t core_req_shr,
    input wire logic [`CSH_ADDR_W-1:0] core_req_addr,
    output logic core_rsp_valid,
    output csh_moesi_t core_rsp_state,
    output logic core_rsp_from_peer,
    output logic [`CSH_DATA_W-1:0] core_rsp_data,
    output logic csnp_valid,
    output logic [NCORE-1:0] csnp_mask,
    output logic [`CSH_ADDR_W-1:0] csnp_addr,
    output csh_op_t csnp_kind,
    input wire logic csnp_done,
    input wire logic csnp_dirty,
    input wire logic [`CSH_DATA_W-1:0] csnp_data,
    output logic [2:0] l2_victim_way
);
    localparam int IW = $clog2(SETS);
    localparam int TW = `CSH_ADDR_W - `CSH_LINE_OFS - IW;

    // ============================================================
    // Elaboration checks.
    generate
        if (NCORE < 1 || NCORE > `CSH_MAX_CORES) begin : g_bad_ncore
            $error("NCORE must be 1 to 4.");
        end
        if (SETS < 2 || (SETS & (SETS - 1)) != 0) begin : g_bad_sets
            $error("SETS must be a power of two.");
        end
        if (!(L2_KB == 0 || L2_KB == 128 || L2_KB == 256 || L2_KB == 512 || L2_KB == 1024))
        begin : g_bad_l2
            $error("L2_KB must be 0, 128, 256, 512 or 1024.");
        end
    endgenerate

    csh_state_t st_r;
    logic ext_r;
    logic [1:0] id_r;
    csh_op_t op_r;
    csh_shr_t shr_r;
    logic [`CSH_ADDR_W-1:0] addr_r;
    logic [NCORE-1:0] hit_r;
    logic bc_sent_r;
    logic peer_r;
    logic dirty_r;
    logic [`CSH_DATA_W-1:0] buf_r;
    logic [NCORE-1:0] hit;
    logic bc_need;
    logic done;
    csh_moesi_t grant;
    logic [IW-1:0] idx;
    logic [TW-1:0] tag;
    csh_moesi_t dst_r [NCORE][SETS];
    logic [TW-1:0] dtg_r [NCORE][SETS];

    assign idx = addr_r[`CSH_LINE_OFS +: IW];
    assign tag = addr_r[`CSH_ADDR_W-1 -: TW];

    // ============================================================
    // Duplicate tags.
    genvar c;
    generate
        for (c = 0; c < NCORE; c++) begin : g_core
            assign hit[c] = dst_r[c][idx] != CSH_I && dtg_r[c][idx] == tag
                && !(!ext_r && id_r == 2'(c));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    for (int s = 0; s < SETS; s++) begin
                        dst_r[c][s] <= CSH_I;
                        dtg_r[c][s] <= '0;
                    end
                end else if (done) begin
                    if (hit_r[c]) begin
                        if (op_r == CSH_OP_RD_SHARED) begin
                            if (dst_r[c][idx] == CSH_M) begin
                                dst_r[c][idx] <= CSH_O;
                            end else if (dst_r[c][idx] == CSH_E) begin
                                dst_r[c][idx] <= CSH_S;
                            end
                        end else begin
                            dst_r[c][idx] <= CSH_I;
                        end
                    end else if (!ext_r && id_r == 2'(c) && op_r != CSH_OP_MAINT) begin
                        dst_r[c][idx] <= grant;
                        dtg_r[c][idx] <= tag;
                    end
                end
            end
        end
    endgenerate

    // ============================================================
    // Broadcast decision.
    always_comb begin
        bc_need = (shr_r == CSH_SHR_INNER && lnk.inner_domain_broadcast)
            || (shr_r == CSH_SHR_OUTER && lnk.outer_domain_broadcast);
        if (op_r == CSH_OP_MAINT) begin
            bc_need = bc_need || lnk.downstream_cache_maint_broadcast;
        end else if (op_r == CSH_OP_EVICT) begin
            bc_need = 1'b0;
        end
    end

    // ============================================================
    // State granted to the requesting core.
    always_comb begin
        unique case (op_r)
            CSH_OP_RD_SHARED: grant = (peer_r || bc_sent_r) ? CSH_S : CSH_E;
            CSH_OP_RD_UNIQUE: grant = dirty_r ? CSH_M : CSH_E;
            default: grant = CSH_I;
        endcase
    end

    assign done = st_r == CSH_RESP && (ext_r ? lnk.sresp_ready : 1'b1);

    // ============================================================
    // Sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= CSH_IDLE;
            ext_r <= 1'b0;
            id_r <= 2'h0;
            op_r <= CSH_OP_RD_SHARED;
            shr_r <= CSH_SHR_NON;
            addr_r <= '0;
            hit_r <= '0;
            bc_sent_r <= 1'b0;
        end else begin
            unique case (st_r)
                CSH_IDLE: begin
                    bc_sent_r <= 1'b0;
                    if (lnk.snp_valid) begin
                        ext_r <= 1'b1;
                        op_r <= lnk.snp_kind;
                        shr_r <= CSH_SHR_NON;
                        addr_r <= lnk.snp_addr;
                        st_r <= CSH_LOOK;
                    end else if (core_req_valid && core_req_id < NCORE) begin
                        ext_r <= 1'b0;
                        id_r <= core_req_id;
                        op_r <= core_req_op;
                        shr_r <= core_req_shr;
                        addr_r <= core_req_addr;
                        st_r <= CSH_LOOK;
                    end
                end
                CSH_LOOK: begin
                    hit_r <= (!ext_r && op_r == CSH_OP_EVICT) ? '0 : hit;
                    if (|hit && !(!ext_r && op_r == CSH_OP_EVICT)) begin
                        st_r <= CSH_CSNP;
                    end else if (!ext_r && bc_need) begin
                        st_r <= CSH_BCAST;
                    end else begin
                        st_r <= CSH_RESP;
                    end
                end
                CSH_CSNP: begin
                    if (csnp_done) begin
                        st_r <= (!ext_r && bc_need) ? CSH_BCAST : CSH_RESP;
                    end
                end
                CSH_BCAST: begin
                    if (lnk.bc_ready) begin
                        bc_sent_r <= 1'b1;
                        st_r <= CSH_RESP;
                    end
                end
                CSH_RESP: begin
                    if (done) begin
                        st_r <= CSH_IDLE;
                    end
                end
                default: st_r <= CSH_IDLE;
            endcase
        end
    end

    // ============================================================
    // Line buffer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_r <= '0;
            dirty_r <= 1'b0;
            peer_r <= 1'b0;
        end else if (st_r == CSH_LOOK) begin
            buf_r <= '0;
            dirty_r <= 1'b0;
            peer_r <= 1'b0;
        end else if (st_r == CSH_CSNP && csnp_done) begin
            buf_r <= csnp_data;
            dirty_r <= csnp_dirty;
            peer_r <= 1'b1;
        end
    end

    // ============================================================
    // Core response.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_rsp_valid <= 1'b0;
            core_rsp_state <= CSH_I;
            core_rsp_from_peer <= 1'b0;
            core_rsp_data <= '0;
        end else begin
            core_rsp_valid <= done && !ext_r;
            if (done && !ext_r) begin
                core_rsp_state <= grant;
                core_rsp_from_peer <= peer_r;
                core_rsp_data <= buf_r;
            end
        end
    end

    // ============================================================
    // Victim way.
    logic [7:0] lfsr_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_r <= 8'h01;
        end else if (L2_KB != 0 && done && !ext_r) begin
            lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        end
    end
    assign l2_victim_way = lfsr_r[2:0];

    assign core_req_ready = st_r == CSH_IDLE && !lnk.snp_valid;
    assign lnk.snp_ready = st_r == CSH_IDLE;
    assign csnp_valid = st_r == CSH_CSNP;
    assign csnp_mask = hit_r;
    assign csnp_addr = addr_r;
    assign csnp_kind = op_r;
    assign lnk.sresp_valid = st_r == CSH_RESP && ext_r;
    assign lnk.sresp_hit = |hit_r;
    assign lnk.sresp_dirty = dirty_r;
    assign lnk.sresp_data = buf_r;
    assign lnk.bc_valid = st_r == CSH_BCAST;
    assign lnk.bc_addr = addr_r;
    assign lnk.bc_op = op_r;
    assign lnk.bc_shr = shr_r;
endmodule : csh_hub

// *** csh_map.svh ***
// How it works
// - Hub serves one to four cores.
// - Hub runs on the cores' clock.
// - Lines tracked with MOESI states.
// - Peer line data moved through hub buffer.
// - Dirty migrated line stays dirty, no writeback.
// - Duplicate tags checked for every coherent request except core evictions.
// - Duplicate tags filter system snoops.
// - Snoop goes only to holding cores.
// - System snoops win over core requests.
// - Inner pin high: inner operations except evictions go out.
// - Inner pin low: inner operations stay local, except maintenance when the maintenance pin is high.
// - Outer pin high: outer operations except evictions go out.
// - Outer pin low: outer operations stay local, except maintenance when the maintenance pin is high.
// - Maintenance pin high: maintenance goes out.
// - Maintenance pin low: maintenance goes out only by its inner or outer pin.
// - Inner pin high only with outer high.
// - Mixed clusters drive inner and outer high.
// - System data bus is 128 bits.
// - Shared cache sizes 128KB to 1MB.
// - Shared cache 64-byte lines, 8 ways, random victim.
`ifndef CSH_MAP_SVH
`define CSH_MAP_SVH
// ============================================================
// Widths.
`define CSH_ADDR_W 32
`define CSH_DATA_W 128
`define CSH_LINE_OFS 6
`define CSH_L2_WAYS 8
`define CSH_MAX_CORES 4
// ============================================================
// System end register offsets.
`define CSH_REG_CFG 12'h000
`define CSH_REG_SNP_ADDR 12'h004
`define CSH_REG_SNP_CMD 12'h008
`define CSH_REG_STATUS 12'h00c
`define CSH_REG_DATA0 12'h010
`define CSH_REG_DATA3 12'h01c
`define CSH_REG_BC_ADDR 12'h020
`define CSH_REG_BC_INFO 12'h024
// ============================================================
// Field positions.
`define CSH_CFG_INNER 0
`define CSH_CFG_OUTER 1
`define CSH_CFG_MAINT 2
`define CSH_CFG_MIXED 3
`define CSH_CFG_RUN 4
`define CSH_ST_BUSY 0
`define CSH_ST_HIT 1
`define CSH_ST_DIRTY 2
`define CSH_ST_BCAST 3
`define CSH_ST_DONE 4
`endif

// *** csh_pkg.sv ***
package csh_pkg;
    typedef enum logic [2:0] {
        CSH_I = 3'h0,
        CSH_S = 3'h1,
        CSH_E = 3'h2,
        CSH_O = 3'h3,
        CSH_M = 3'h4
    } csh_moesi_t;
    typedef enum logic [1:0] {
        CSH_OP_RD_SHARED = 2'h0,
        CSH_OP_RD_UNIQUE = 2'h1,
        CSH_OP_EVICT = 2'h2,
        CSH_OP_MAINT = 2'h3
    } csh_op_t;
    typedef enum logic [1:0] {
        CSH_SHR_NON = 2'h0,
        CSH_SHR_INNER = 2'h1,
        CSH_SHR_OUTER = 2'h2
    } csh_shr_t;
    typedef enum logic [4:0] {
        CSH_IDLE = 5'h01,
        CSH_LOOK = 5'h02,
        CSH_CSNP = 5'h04,
        CSH_BCAST = 5'h08,
        CSH_RESP = 5'h10
    } csh_state_t;
endpackage : csh_pkg

// *** csh_if.sv ***
`timescale 1ns/1ps
`include "csh_map.svh"
interface csh_if;
    import csh_pkg::*;
    logic inner_domain_broadcast;
    logic outer_domain_broadcast;
    logic downstream_cache_maint_broadcast;
    logic snp_valid;
    logic snp_ready;
    logic [`CSH_ADDR_W-1:0] snp_addr;
    csh_op_t snp_kind;
    logic sresp_valid;
    logic sresp_ready;
    logic sresp_hit;
    logic sresp_dirty;
    logic [`CSH_DATA_W-1:0] sresp_data;
    logic bc_valid;
    logic bc_ready;
    logic [`CSH_ADDR_W-1:0] bc_addr;
    csh_op_t bc_op;
    csh_shr_t bc_shr;
    modport hub (
        input inner_domain_broadcast, outer_domain_broadcast, downstream_cache_maint_broadcast,
        input snp_valid, snp_addr, snp_kind, sresp_ready, bc_ready,
        output snp_ready, sresp_valid, sresp_hit, sresp_dirty, sresp_data,
        output bc_valid, bc_addr, bc_op, bc_shr
    );
    modport sys (
        output inner_domain_broadcast, outer_domain_broadcast, downstream_cache_maint_broadcast,
        output snp_valid, snp_addr, snp_kind, sresp_ready, bc_ready,
        input snp_ready, sresp_valid, sresp_hit, sresp_dirty, sresp_data,
        input bc_valid, bc_addr, bc_op, bc_shr
    );
endinterface : csh_if

// *** csh_sys_end.sv ***
`timescale 1ns/1ps
`include "csh_map.svh"
module csh_sys_end
    import csh_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    csh_if.sys lnk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [4:0] cfg_r;
    logic [`CSH_ADDR_W-1:0] snp_addr_r;
    csh_op_t snp_kind_r;
    logic snp_valid_r;
    logic busy_r;
    logic hit_r;
    logic dirty_r;
    logic bcast_r;
    logic sdone_r;
    logic [`CSH_DATA_W-1:0] data_r;
    logic [`CSH_ADDR_W-1:0] bc_addr_r;
    logic [1:0] bc_op_r;
    logic [7:0] bc_cnt_r;
    logic inner_r;
    logic outer_r;
    logic maint_r;
    logic wr;
    logic mapped;
    logic [31:0] rd;

    assign wr = psel && penable && pwrite;
    assign mapped = paddr <= `CSH_REG_BC_INFO && paddr[1:0] == 2'h0;

    // ============================================================
    // Configuration.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= 5'h00;
            inner_r <= 1'b0;
            outer_r <= 1'b0;
            maint_r <= 1'b0;
        end else begin
            if (wr && paddr == `CSH_REG_CFG) begin
                cfg_r <= pwdata[4:0];
            end
            if (!cfg_r[`CSH_CFG_RUN]) begin
                outer_r <= cfg_r[`CSH_CFG_OUTER] || cfg_r[`CSH_CFG_MIXED];
                inner_r <= (cfg_r[`CSH_CFG_INNER] || cfg_r[`CSH_CFG_MIXED])
                    && (cfg_r[`CSH_CFG_OUTER] || cfg_r[`CSH_CFG_MIXED]);
                maint_r <= cfg_r[`CSH_CFG_MAINT];
            end
        end
    end
    assign lnk.inner_domain_broadcast = inner_r;
    assign lnk.outer_domain_broadcast = outer_r;
    assign lnk.downstream_cache_maint_broadcast = maint_r;

    // ============================================================
    // Snoop issue.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snp_addr_r <= '0;
            snp_kind_r <= CSH_OP_RD_SHARED;
            snp_valid_r <= 1'b0;
            busy_r <= 1'b0;
            hit_r <= 1'b0;
            dirty_r <= 1'b0;
            data_r <= '0;
        end else begin
            if (wr && paddr == `CSH_REG_SNP_ADDR && !busy_r) begin
                snp_addr_r <= pwdata;
            end
            if (wr && paddr == `CSH_REG_SNP_CMD && !busy_r) begin
                snp_kind_r <= csh_op_t'(pwdata[1:0]);
                snp_valid_r <= 1'b1;
                busy_r <= 1'b1;
            end else if (snp_valid_r && lnk.snp_ready) begin
                snp_valid_r <= 1'b0;
            end else if (busy_r && !snp_valid_r && lnk.sresp_valid) begin
                busy_r <= 1'b0;
                hit_r <= lnk.sresp_hit;
                dirty_r <= lnk.sresp_dirty;
                data_r <= lnk.sresp_data;
            end
        end
    end
    assign lnk.snp_valid = snp_valid_r;
    assign lnk.snp_addr = snp_addr_r;
    assign lnk.snp_kind = snp_kind_r;
    assign lnk.sresp_ready = busy_r && !snp_valid_r;
    assign lnk.bc_ready = 1'b1;

    // ============================================================
    // Sticky flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcast_r <= 1'b0;
            sdone_r <= 1'b0;
            bc_addr_r <= '0;
            bc_op_r <= 2'h0;
            bc_cnt_r <= 8'h00;
        end else begin
            if (lnk.bc_valid) begin
                bcast_r <= 1'b1;
                bc_addr_r <= lnk.bc_addr;
                bc_op_r <= lnk.bc_op;
                bc_cnt_r <= bc_cnt_r + 8'h01;
            end else if (wr && paddr == `CSH_REG_STATUS && pwdata[`CSH_ST_BCAST]) begin
                bcast_r <= 1'b0;
            end
            if (busy_r && !snp_valid_r && lnk.sresp_valid) begin
                sdone_r <= 1'b1;
            end else if (wr && paddr == `CSH_REG_STATUS && pwdata[`CSH_ST_DONE]) begin
                sdone_r <= 1'b0;
            end
        end
    end

    // ============================================================
    // Read mux.
    always_comb begin
        rd = 32'h0000_0000;
        if (paddr == `CSH_REG_CFG) begin
            rd = {27'h0, cfg_r};
        end else if (paddr == `CSH_REG_SNP_ADDR) begin
            rd = snp_addr_r;
        end else if (paddr == `CSH_REG_SNP_CMD) begin
            rd = {30'h0, snp_kind_r};
        end else if (paddr == `CSH_REG_STATUS) begin
            rd = {27'h0, sdone_r, bcast_r, dirty_r, hit_r, busy_r};
        end else if (paddr >= `CSH_REG_DATA0 && paddr <= `CSH_REG_DATA3) begin
            rd = data_r[{paddr[3:2], 5'h00} +: 32];
        end else if (paddr == `CSH_REG_BC_ADDR) begin
            rd = bc_addr_r;
        end else if (paddr == `CSH_REG_BC_INFO) begin
            rd = {16'h0, bc_cnt_r, 6'h00, bc_op_r};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= mapped ? rd : 32'h0000_0000;
        end
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
endmodule : csh_sys_end

// *** csh_chk.sv ***
`timescale 1ns/1ps
`include "csh_map.svh"
// ====
// Link checks.
module csh_chk
    import csh_pkg::*;
(
    input logic pclk,
    input logic presetn,
    input logic inner_domain_broadcast,
    input logic outer_domain_broadcast,
    input logic downstream_cache_maint_broadcast,
    input logic snp_valid,
    input logic snp_ready,
    input logic sresp_valid,
    input logic sresp_hit,
    input logic sresp_dirty,
    input logic bc_valid,
    input csh_op_t bc_op,
    input csh_shr_t bc_shr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_take;
        snp_valid && snp_ready;
    endsequence
    sequence s_answer;
        ##[1:40] sresp_valid;
    endsequence
    a_snoop_answered: assert property (s_take |=> s_answer)
        else $error("no snoop answer");
    a_take_busy: assert property (s_take |=> !snp_ready)
        else $error("ready after take");
    a_resp_busy: assert property (sresp_valid |-> !snp_ready)
        else $error("ready while answering");
    a_dirty_hit: assert property (sresp_valid && sresp_dirty |-> sresp_hit)
        else $error("dirty without hit");
    a_inner_outer: assert property (inner_domain_broadcast |-> outer_domain_broadcast)
        else $error("inner without outer");
    a_inner_gate: assert property (bc_valid && bc_shr == CSH_SHR_INNER
        && bc_op != CSH_OP_MAINT |-> inner_domain_broadcast)
        else $error("inner op sent");
    a_outer_gate: assert property (bc_valid && bc_shr == CSH_SHR_OUTER
        && bc_op != CSH_OP_MAINT |-> outer_domain_broadcast)
        else $error("outer op sent");
    a_maint_gate: assert property (bc_valid && bc_op == CSH_OP_MAINT |->
        downstream_cache_maint_broadcast || (bc_shr == CSH_SHR_INNER && inner_domain_broadcast)
        || (bc_shr == CSH_SHR_OUTER && outer_domain_broadcast))
        else $error("local maintenance sent");
    a_no_evict: assert property (bc_valid |-> bc_op != CSH_OP_EVICT)
        else $error("eviction sent");
    a_share_gate: assert property (bc_valid && bc_op != CSH_OP_MAINT |-> bc_shr != CSH_SHR_NON)
        else $error("non-shareable op sent");
endmodule : csh_chk

// *** cluster_snoop_coherency_unit_tb.sv ***
`timescale 1ns/1ps
`include "csh_map.svh"
module cluster_snoop_coherency_unit_tb;
    import csh_pkg::*;
    // ====
    // Stimulus and observation.
    localparam logic [127:0] LINE = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0;
    localparam logic [3:0] BCFG [7] = '{4'h3, 4'h2, 4'h2, 4'h0, 4'h4, 4'h0, 4'h7};
    localparam logic [1:0] BOP [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h3, 2'h3, 2'h2};
    localparam logic [1:0] BSHR [7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1};
    localparam logic BEXP [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    localparam logic [31:0] A = 32'h0000_1040;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q, bc_addr_seen;
    logic pready, pslverr, e, core_req_valid = 1'b0, core_req_ready, core_rsp_valid;
    logic core_rsp_from_peer, csnp_valid, csnp_done = 1'b0, csnp_dirty = 1'b1;
    logic [1:0] core_req_id = 2'h0;
    csh_op_t core_req_op = CSH_OP_RD_SHARED, bc_op_seen;
    csh_shr_t core_req_shr = CSH_SHR_NON, bc_shr_seen;
    logic [31:0] core_req_addr = 32'h0;
    csh_moesi_t core_rsp_state;
    logic [127:0] core_rsp_data;
    logic [3:0] csnp_mask, last_mask = 4'h0;
    logic [2:0] csnp_cnt = 3'h0;
    int n_csnp = 0, n_bc = 0, n_errors = 0, checks = 0, k;
    csh_if lnk ();
    csh_hub #(.NCORE(4), .SETS(64), .L2_KB(128)) csh_hub_inst (.pclk(pclk), .presetn(presetn),
        .lnk(lnk), .core_req_valid(core_req_valid), .core_req_ready(core_req_ready),
        .core_req_id(core_req_id), .core_req_op(core_req_op), .core_req_shr(core_req_shr),
        .core_req_addr(core_req_addr), .core_rsp_valid(core_rsp_valid),
        .core_rsp_state(core_rsp_state), .core_rsp_from_peer(core_rsp_from_peer),
        .core_rsp_data(core_rsp_data), .csnp_valid(csnp_valid), .csnp_mask(csnp_mask),
        .csnp_addr(), .csnp_kind(), .csnp_done(csnp_done), .csnp_dirty(csnp_dirty),
        .csnp_data(LINE), .l2_victim_way());
    csh_sys_end csh_sys_end_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    csh_chk csh_chk_inst (.pclk(pclk), .presetn(presetn),
        .inner_domain_broadcast(lnk.inner_domain_broadcast),
        .outer_domain_broadcast(lnk.outer_domain_broadcast),
        .downstream_cache_maint_broadcast(lnk.downstream_cache_maint_broadcast),
        .snp_valid(lnk.snp_valid), .snp_ready(lnk.snp_ready), .sresp_valid(lnk.sresp_valid),
        .sresp_hit(lnk.sresp_hit), .sresp_dirty(lnk.sresp_dirty), .bc_valid(lnk.bc_valid),
        .bc_op(lnk.bc_op), .bc_shr(lnk.bc_shr));
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        csnp_cnt <= csnp_valid ? csnp_cnt + 3'h1 : 3'h0;
        csnp_done <= csnp_valid && csnp_cnt == 3'h1;
        if (csnp_valid && csnp_cnt == 3'h0) begin
            last_mask <= csnp_mask;
            n_csnp <= n_csnp + 1;
        end
        if (lnk.bc_valid && lnk.bc_ready) begin
            n_bc <= n_bc + 1;
            bc_op_seen <= lnk.bc_op;
            bc_shr_seen <= lnk.bc_shr;
            bc_addr_seen <= lnk.bc_addr;
        end
    end
    // ====
    // Shared tasks.
    task stop_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    task check(input string name, input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task bound(input int i);
        if (i >= 50) begin
            n_errors++;
            stop_test();
        end
    endtask : bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        bound(i);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task cfg(input logic [31:0] d);
        apb(1'b1, `CSH_REG_CFG, d);
        repeat (2) @(posedge pclk);
    endtask : cfg
    task core(input logic [1:0] id, input csh_op_t op, input csh_shr_t shr, input logic [31:0] a);
        int i;
        @(posedge pclk);
        core_req_valid <= 1'b1;
        core_req_id <= id;
        core_req_op <= op;
        core_req_shr <= shr;
        core_req_addr <= a;
        for (i = 0; i < 50; i++) begin
            @(negedge pclk);
            if (core_req_ready === 1'b1) break;
        end
        bound(i);
        @(posedge pclk);
        core_req_valid <= 1'b0;
        for (i = 0; i < 50; i++) begin
            @(negedge pclk);
            if (core_rsp_valid === 1'b1) break;
        end
        bound(i);
    endtask : core
    task poll();
        int i;
        for (i = 0; i < 50; i++) begin
            apb(1'b0, `CSH_REG_STATUS, 32'h0);
            if (q[`CSH_ST_DONE] === 1'b1) break;
        end
        bound(i);
    endtask : poll
    // ====
    // Scenarios.
    task t_regs();
        apb(1'b0, `CSH_REG_CFG, 32'h0);
        check("cfg reset", q, 32'h0);
        check("pins reset", {lnk.inner_domain_broadcast, lnk.outer_domain_broadcast}, 2'b00);
        apb(1'b0, 12'h028, 32'h0);
        check("unmapped error", e, 1'b1);
        apb(1'b1, 12'h002, 32'hffff_ffff);
        check("unaligned error", e, 1'b1);
    endtask : t_regs
    task t_pins();
        cfg(32'h01);
        check("inner alone", lnk.inner_domain_broadcast, 1'b0);
        cfg(32'h03);
        cfg(32'h13);
        cfg(32'h10);
        check("pins held in run", {lnk.inner_domain_broadcast, lnk.outer_domain_broadcast}, 2'b11);
        cfg(32'h04);
        check("maint pin", {lnk.inner_domain_broadcast, lnk.downstream_cache_maint_broadcast}, 2'b01);
        cfg(32'h08);
        check("mixed", {lnk.inner_domain_broadcast, lnk.outer_domain_broadcast}, 2'b11);
    endtask : t_pins
    task t_migrate();
        cfg(32'h0);
        core(2'h0, CSH_OP_RD_UNIQUE, CSH_SHR_NON, A);
        check("miss grant", core_rsp_state, CSH_E);
        core(2'h1, CSH_OP_RD_SHARED, CSH_SHR_NON, A);
        check("shared grant", core_rsp_state, CSH_S);
        check("peer data", {core_rsp_from_peer, core_rsp_data}, {1'b1, LINE});
        check("holder mask", last_mask, 4'b0001);
        core(2'h2, CSH_OP_RD_UNIQUE, CSH_SHR_NON, A);
        check("dirty grant", core_rsp_state, CSH_M);
        check("holders", last_mask, 4'b0011);
        check("no writeback", 128'(n_bc), 128'h0);
    endtask : t_migrate
    task t_snoop();
        apb(1'b1, `CSH_REG_SNP_ADDR, A);
        apb(1'b1, `CSH_REG_SNP_CMD, 32'h0);
        poll();
        check("snoop hit dirty", q[2:1], 2'b11);
        check("snoop target", last_mask, 4'b0100);
        apb(1'b0, `CSH_REG_DATA0, 32'h0);
        check("data low", q, LINE[31:0]);
        apb(1'b0, `CSH_REG_DATA3, 32'h0);
        check("data high", q, LINE[127:96]);
        apb(1'b1, `CSH_REG_STATUS, 32'h18);
        k = n_csnp;
        apb(1'b1, `CSH_REG_SNP_ADDR, 32'h0000_5000);
        apb(1'b1, `CSH_REG_SNP_CMD, 32'h1);
        poll();
        check("miss filtered", {q[1], 32'(n_csnp - k)}, 33'h0);
    endtask : t_snoop
    task t_bcast();
        int i;
        for (i = 0; i < 7; i++) begin
            k = n_bc;
            cfg({28'h0, BCFG[i]});
            core(2'h3, csh_op_t'(BOP[i]), csh_shr_t'(BSHR[i]), 32'h0002_0000 + 32'(i * 64));
            check("bcast count", 32'(n_bc - k), {31'h0, BEXP[i]});
            if (BEXP[i]) begin
                check("bcast op", {bc_op_seen, bc_shr_seen}, {BOP[i], BSHR[i]});
                check("bcast addr", bc_addr_seen, 32'h0002_0000 + 32'(i * 64));
            end
        end
    endtask : t_bcast
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pins();
        t_migrate();
        t_snoop();
        t_bcast();
        stop_test();
    end
endmodule : cluster_snoop_coherency_unit_tb
